// file: touch_consts.vh
`ifndef TOUCH_CONSTS_VH
`define TOUCH_CONSTS_VH

// Register indices; byte address is four times the index
`define CTRL_INDEX 10'h069
`define START_INDEX 10'h06A
`define STATUS_INDEX 10'h070
`define MASK_INDEX 10'h071
`define STATE_INDEX 10'h072

// Control and start register fields
`define AUTO_EN_BIT 0
`define DET_EN_BIT 1
`define SEL_BIT 2
`define IDLE_LSB 3
`define IDLE_MSB 5
`define SETTLE_LSB 6
`define SETTLE_MSB 7
`define MANUAL_BIT 6
`define CTRL_RESET 8'h00

// Idle interval decode, in slots
`define IDLE_SLOTS_0 9'h000
`define IDLE_SLOTS_1 9'h002
`define IDLE_SLOTS_2 9'h005
`define IDLE_SLOTS_3 9'h00A
`define IDLE_SLOTS_4 9'h01E
`define IDLE_SLOTS_5 9'h050
`define IDLE_SLOTS_6 9'h082
`define IDLE_SLOTS_7 9'h14A

// Settle interval decode, in slots
`define SETTLE_SLOTS_0 9'h000
`define SETTLE_SLOTS_1 9'h001
`define SETTLE_SLOTS_2 9'h002
`define SETTLE_SLOTS_3 9'h004

// Slot timing
`define SLOT_TIME_NS 50000
`define CLK_PERIOD_NS 4

// Panel switch patterns {Y-, Y+, X-, X+} and mux codes
`define SW_OPEN 4'h0
`define SW_X 4'h3
`define SW_Y 4'hC
`define SW_Z 4'h6
`define MUX_XP 2'h0
`define MUX_YP 2'h1

// Event bits
`define EV_SEQ 0
`define EV_TOUCH 1
`define EV_MEAS 2
`define EV_WIDTH 3

// Bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// file: bit_sync.v
`timescale 1ns/1ns
// Two-stage synchroniser for asynchronous levels
module bit_sync #(
    parameter WIDTH = 1
) (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Levels
    input wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] stage1_reg; // Read only by stage2_reg
    reg [WIDTH-1:0] stage2_reg; // Safe copy

    // Plain two-flop chain
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1_reg <= {WIDTH{1'b0}};
            stage2_reg <= {WIDTH{1'b0}};
        end else begin
            stage1_reg <= async_in;
            stage2_reg <= stage1_reg;
        end
    end

    assign sync_out = stage2_reg;
endmodule // bit_sync

// file: slot_timer.v
`timescale 1ns/1ns
// Free-running conversion slot timer; one-cycle tick per slot boundary
module slot_timer #(
    parameter SLOT_CYCLES = 12500,
    parameter CW = 16
) (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Slot boundary pulse
    output reg tick
);
    reg [CW-1:0] count_reg; // Cycles into current slot

    // Wraps at SLOT_CYCLES so the boundary cadence matches the shared ADC
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= {CW{1'b0}};
            tick <= 1'b0;
        end else if (count_reg == SLOT_CYCLES[CW-1:0] - 1'b1) begin
            count_reg <= {CW{1'b0}};
            tick <= 1'b1;
        end else begin
            count_reg <= count_reg + 1'b1;
            tick <= 1'b0;
        end
    end
endmodule // slot_timer

// file: touch_sequence_scheduler.v
// Notes on behaviour
// - Control bit 0 enables automatic sequences
// - Control bit 1 enables contact detect, repeating
// - Select 0: X, Y, Z, X, Y with checks
// - Select 1: X-only, each followed by check
// - Repeat while contact present, else one sequence
// - Bits 5:3 choose idle slots between groups
// - Idle gaps keep every panel switch open
// - Bits 7:6 choose settle slots before conversion
// - Code 00 closes inside slot, 01 earlier
// - Switches set, settle, then sample, repeating
// - Settle up to one slot: back-to-back readings
// - Manual start runs one sequence, then self-clears
// - Read-only contact present status stops repeats
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "touch_consts.vh"
module touch_sequence_scheduler #(
    parameter SLOT_CYCLES = `SLOT_TIME_NS / `CLK_PERIOD_NS,
    parameter AW = 12
) (
    // Clock and reset
    input wire CLK,
    input wire RST_B,
    // AXI4-Lite write address and data
    input wire [AW-1:0] S_AXI_AWADDR,
    input wire S_AXI_AWVALID,
    output wire S_AXI_AWREADY,
    input wire [31:0] S_AXI_WDATA,
    input wire [3:0] S_AXI_WSTRB,
    input wire S_AXI_WVALID,
    output wire S_AXI_WREADY,
    // AXI4-Lite write response
    output reg [1:0] S_AXI_BRESP,
    output reg S_AXI_BVALID,
    input wire S_AXI_BREADY,
    // AXI4-Lite read
    input wire [AW-1:0] S_AXI_ARADDR,
    input wire S_AXI_ARVALID,
    output wire S_AXI_ARREADY,
    output reg [31:0] S_AXI_RDATA,
    output reg [1:0] S_AXI_RRESP,
    output reg S_AXI_RVALID,
    input wire S_AXI_RREADY,
    // Panel and ADC side
    input wire CONTACT_IN,
    output reg [3:0] PANEL_SW,
    output reg [1:0] ADC_MUX,
    output reg ADC_CONVERT,
    output reg DETECT_EN,
    // Interrupt
    output wire IRQ
);
    // One-hot states
    localparam ST_IDLE = 5'b00001;
    localparam ST_SETTLE = 5'b00010;
    localparam ST_CONVERT = 5'b00100;
    localparam ST_CHECK = 5'b01000;
    localparam ST_GAP = 5'b10000;

    reg [1:0] rst_sync_reg; // Reset release chain
    wire rst_n; // Synchronised reset
    wire tick; // Slot boundary
    wire contact_sync; // Synchronised contact comparator

    // Reset asserts at once, releases after two edges
    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            rst_sync_reg <= 2'b00;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    slot_timer #(.SLOT_CYCLES(SLOT_CYCLES), .CW(32)) u_slot (
        .clk(CLK),
        .rst_n(rst_n),
        .tick(tick)
    );

    bit_sync #(.WIDTH(1)) u_contact_sync (
        .clk(CLK),
        .rst_n(rst_n),
        .async_in(CONTACT_IN),
        .sync_out(contact_sync)
    );

    // Software-visible state
    reg [7:0] ctrl_reg; // Control register
    reg manual_reg; // Manual start request
    reg contact_reg; // Contact present status
    reg [`EV_WIDTH-1:0] status_reg; // Sticky events
    reg [`EV_WIDTH-1:0] mask_reg; // Interrupt enables
    wire auto_en = ctrl_reg[`AUTO_EN_BIT];
    wire det_en = ctrl_reg[`DET_EN_BIT];
    wire x_only = ctrl_reg[`SEL_BIT];

    // Sequencer state
    reg [4:0] state_reg, state_next;
    reg [2:0] step_reg, step_next; // Measurement index in sequence
    reg [8:0] cnt_reg, cnt_next; // Slots left in settle or gap
    reg [8:0] idle_slots; // Decoded idle interval
    reg [8:0] settle_slots; // Decoded settle interval
    reg seq_end; // Last check of sequence finishing
    reg conv_start; // Entering a conversion slot
    reg [`EV_WIDTH-1:0] events; // Event pulses this cycle
    wire last_step = x_only ? 1'b1 : (step_reg == 3'd4);
    wire start_req = auto_en & (manual_reg | (det_en & contact_reg));

    // Interval decode, all in slot units
    always @* begin
        case (ctrl_reg[`IDLE_MSB:`IDLE_LSB])
            3'd0: idle_slots = `IDLE_SLOTS_0;
            3'd1: idle_slots = `IDLE_SLOTS_1;
            3'd2: idle_slots = `IDLE_SLOTS_2;
            3'd3: idle_slots = `IDLE_SLOTS_3;
            3'd4: idle_slots = `IDLE_SLOTS_4;
            3'd5: idle_slots = `IDLE_SLOTS_5;
            3'd6: idle_slots = `IDLE_SLOTS_6;
            default: idle_slots = `IDLE_SLOTS_7;
        endcase
        case (ctrl_reg[`SETTLE_MSB:`SETTLE_LSB])
            2'd0: settle_slots = `SETTLE_SLOTS_0;
            2'd1: settle_slots = `SETTLE_SLOTS_1;
            2'd2: settle_slots = `SETTLE_SLOTS_2;
            default: settle_slots = `SETTLE_SLOTS_3;
        endcase
    end

    // Next state; moves only on slot boundaries
    always @* begin
        state_next = state_reg;
        step_next = step_reg;
        cnt_next = cnt_reg;
        seq_end = 1'b0;
        conv_start = 1'b0;
        if (tick) begin
            case (state_reg)
                ST_IDLE: begin
                    if (start_req) begin
                        step_next = 3'd0;
                        // Zero settle closes switches in the conversion slot
                        if (settle_slots == 9'd0) begin
                            state_next = ST_CONVERT;
                            conv_start = 1'b1;
                        end else begin
                            state_next = ST_SETTLE;
                            cnt_next = settle_slots - 9'd1;
                        end
                    end
                end
                ST_SETTLE: begin
                    if (cnt_reg == 9'd0) begin
                        state_next = ST_CONVERT;
                        conv_start = 1'b1;
                    end else begin
                        cnt_next = cnt_reg - 9'd1;
                    end
                end
                ST_CONVERT: begin
                    state_next = ST_CHECK;
                end
                ST_CHECK: begin
                    if (!last_step) begin
                        // No gap inside a sequence: back-to-back at small settle
                        step_next = step_reg + 3'd1;
                        if (settle_slots == 9'd0) begin
                            state_next = ST_CONVERT;
                            conv_start = 1'b1;
                        end else begin
                            state_next = ST_SETTLE;
                            cnt_next = settle_slots - 9'd1;
                        end
                    end else begin
                        seq_end = 1'b1;
                        // Repeat only while detection sees a touch
                        if (auto_en & det_en & contact_sync) begin
                            if (idle_slots == 9'd0) begin
                                state_next = ST_IDLE;
                            end else begin
                                state_next = ST_GAP;
                                cnt_next = idle_slots - 9'd1;
                            end
                        end else begin
                            state_next = ST_IDLE;
                        end
                    end
                end
                ST_GAP: begin
                    if (cnt_reg == 9'd0) begin
                        state_next = ST_IDLE;
                    end else begin
                        cnt_next = cnt_reg - 9'd1;
                    end
                end
                default: state_next = ST_IDLE;
            endcase
            // Disabling auto mode abandons any sequence at the next boundary
            if (!auto_en) begin
                state_next = ST_IDLE;
                conv_start = 1'b0;
                seq_end = 1'b0;
            end
        end
        events = {conv_start, 1'b0, seq_end};
        events[`EV_TOUCH] = contact_sync & ~contact_reg & det_en;
    end

    // Sequencer registers and panel drive
    always @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            step_reg <= 3'd0;
            cnt_reg <= 9'd0;
            contact_reg <= 1'b0;
            PANEL_SW <= `SW_OPEN;
            ADC_MUX <= `MUX_XP;
            ADC_CONVERT <= 1'b0;
            DETECT_EN <= 1'b0;
        end else begin
            state_reg <= state_next;
            step_reg <= step_next;
            cnt_reg <= cnt_next;
            ADC_CONVERT <= conv_start;
            // Status follows the comparator only while detection is on
            contact_reg <= det_en & contact_sync;
            // Detect circuit powered outside measurement slots
            DETECT_EN <= det_en & ~state_next[1] & ~state_next[2];
            if (state_next == ST_SETTLE || state_next == ST_CONVERT) begin
                if (x_only || step_next == 3'd0 || step_next == 3'd3) begin
                    PANEL_SW <= `SW_X;
                    ADC_MUX <= `MUX_YP;
                end else if (step_next == 3'd2) begin
                    PANEL_SW <= `SW_Z;
                    ADC_MUX <= `MUX_XP;
                end else begin
                    PANEL_SW <= `SW_Y;
                    ADC_MUX <= `MUX_XP;
                end
            end else begin
                // Idle, gap and checks leave the screen unpowered
                PANEL_SW <= `SW_OPEN;
            end
        end
    end

    // AXI4-Lite slave
    reg aw_held_reg, w_held_reg; // Accepted halves of a write
    reg [9:0] waddr_reg; // Held write index
    reg [7:0] wdata_reg; // Held write byte
    reg wbyte_reg; // Low byte lane enabled
    wire aw_take = S_AXI_AWVALID & S_AXI_AWREADY;
    wire w_take = S_AXI_WVALID & S_AXI_WREADY;
    wire ar_take = S_AXI_ARVALID & S_AXI_ARREADY;
    wire do_write = aw_held_reg & w_held_reg & ~S_AXI_BVALID;
    wire wr_hit = (waddr_reg == `CTRL_INDEX) | (waddr_reg == `START_INDEX) |
                  (waddr_reg == `STATUS_INDEX) | (waddr_reg == `MASK_INDEX) |
                  (waddr_reg == `STATE_INDEX);
    wire [9:0] raddr = S_AXI_ARADDR[11:2];
    reg [31:0] rd_mux; // Read data for raddr
    reg rd_hit; // Read address mapped

    assign S_AXI_AWREADY = ~aw_held_reg & ~S_AXI_BVALID;
    assign S_AXI_WREADY = ~w_held_reg & ~S_AXI_BVALID;
    assign S_AXI_ARREADY = ~S_AXI_RVALID;

    // Read decode; unused bits read as zero
    always @* begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b1;
        case (raddr)
            `CTRL_INDEX: rd_mux[7:0] = ctrl_reg;
            `START_INDEX: rd_mux[`MANUAL_BIT] = manual_reg;
            `STATUS_INDEX: rd_mux[`EV_WIDTH-1:0] = status_reg;
            `MASK_INDEX: rd_mux[`EV_WIDTH-1:0] = mask_reg;
            `STATE_INDEX: rd_mux[12:0] = {cnt_reg, step_reg, contact_reg};
            default: rd_hit = 1'b0;
        endcase
    end

    // Bus handshakes and register writes
    always @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            waddr_reg <= 10'h000;
            wdata_reg <= 8'h00;
            wbyte_reg <= 1'b0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= `RESP_OKAY;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RRESP <= `RESP_OKAY;
            S_AXI_RDATA <= 32'h0000_0000;
            ctrl_reg <= `CTRL_RESET;
            manual_reg <= 1'b0;
            mask_reg <= {`EV_WIDTH{1'b0}};
            status_reg <= {`EV_WIDTH{1'b0}};
        end else begin
            if (aw_take) begin
                aw_held_reg <= 1'b1;
                waddr_reg <= S_AXI_AWADDR[11:2];
            end
            if (w_take) begin
                w_held_reg <= 1'b1;
                wdata_reg <= S_AXI_WDATA[7:0];
                wbyte_reg <= S_AXI_WSTRB[0];
            end
            // Hardware clears the request when its sequence ends
            if (seq_end) begin
                manual_reg <= 1'b0;
            end
            // Events set; a write of one clears, but a new event wins
            status_reg <= status_reg | events;
            if (do_write) begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
                if (wbyte_reg) begin
                    case (waddr_reg)
                        `CTRL_INDEX: ctrl_reg <= wdata_reg;
                        `START_INDEX: begin
                            // Ignored unless auto mode is on
                            if (wdata_reg[`MANUAL_BIT] & auto_en) begin
                                manual_reg <= 1'b1;
                            end
                        end
                        `STATUS_INDEX: begin
                            status_reg <= (status_reg & ~wdata_reg[`EV_WIDTH-1:0]) | events;
                        end
                        `MASK_INDEX: mask_reg <= wdata_reg[`EV_WIDTH-1:0];
                        default: begin
                        end
                    endcase
                end
            end else if (S_AXI_BVALID & S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
            if (ar_take) begin
                S_AXI_RVALID <= 1'b1;
                S_AXI_RDATA <= rd_mux;
                S_AXI_RRESP <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
            end else if (S_AXI_RVALID & S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'b0;
            end
        end
    end

    // Level interrupt from unmasked sticky events
    assign IRQ = |(status_reg & mask_reg);
endmodule // touch_sequence_scheduler

// file: touch_monitor.sv
`timescale 1ns/1ns
module touch_monitor #(
    parameter int SLOT_CYCLES = 20
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_B,
    // Bus answers
    input wire logic [1:0] S_AXI_BRESP,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic S_AXI_ARREADY,
    // Panel side
    input wire logic [3:0] PANEL_SW,
    input wire logic [1:0] ADC_MUX,
    input wire logic ADC_CONVERT,
    input wire logic DETECT_EN
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_B);
    // Closed-switch run length; caps settle plus conversion time
    int closed_cnt;
    // Counter restarts whenever every switch is open
    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            closed_cnt <= 0;
        end else if (PANEL_SW == 4'h0) begin
            closed_cnt <= 0;
        end else begin
            closed_cnt <= closed_cnt + 1;
        end
    end
    sequence s_quiet; !ADC_CONVERT [*8]; endsequence
    sequence s_hold; $stable(PANEL_SW) [*8]; endsequence
    property p_conv_pulse; ADC_CONVERT |=> s_quiet; endproperty
    property p_conv_closed; ADC_CONVERT |-> PANEL_SW != 4'h0; endproperty
    property p_sw_legal; PANEL_SW inside {4'h0, 4'h3, 4'hC, 4'h6}; endproperty
    property p_x_mux; PANEL_SW == 4'h3 |-> ADC_MUX == 2'h1; endproperty
    property p_detect_open; DETECT_EN |-> PANEL_SW == 4'h0; endproperty
    property p_settle_bound; closed_cnt <= 5 * SLOT_CYCLES + 1; endproperty
    property p_sw_hold; $changed(PANEL_SW) && PANEL_SW != 4'h0 |=> s_hold; endproperty
    property p_b_hold;
        S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP);
    endproperty
    property p_r_hold;
        S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA);
    endproperty
    property p_ar_block; S_AXI_RVALID |-> !S_AXI_ARREADY; endproperty
    a_conv_pulse: assert property (p_conv_pulse) else $error("convert pulse too long");
    a_conv_closed: assert property (p_conv_closed) else $error("convert with open sw");
    a_sw_legal: assert property (p_sw_legal) else $error("illegal switch pattern");
    a_x_mux: assert property (p_x_mux) else $error("x measurement wrong mux");
    a_detect_open: assert property (p_detect_open) else $error("detect with sw closed");
    a_settle_bound: assert property (p_settle_bound) else $error("switches closed too long");
    a_sw_hold: assert property (p_sw_hold) else $error("switch pattern unstable");
    a_b_hold: assert property (p_b_hold) else $error("write response dropped");
    a_r_hold: assert property (p_r_hold) else $error("read data dropped");
    a_ar_block: assert property (p_ar_block) else $error("read taken while busy");
endmodule // touch_monitor

bind touch_sequence_scheduler touch_monitor #(.SLOT_CYCLES(SLOT_CYCLES)) u_mon (
    .CLK(CLK), .RST_B(RST_B), .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID),
    .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID),
    .S_AXI_RREADY(S_AXI_RREADY), .S_AXI_ARREADY(S_AXI_ARREADY), .PANEL_SW(PANEL_SW),
    .ADC_MUX(ADC_MUX), .ADC_CONVERT(ADC_CONVERT), .DETECT_EN(DETECT_EN));

// file: panel_model.sv
`timescale 1ns/1ns
module panel_model (
    // Clock and touch level from the bench
    input wire logic clk,
    input wire logic touch,
    // Scheduler outputs
    input wire logic [1:0] adc_mux,
    input wire logic adc_convert,
    input wire logic detect_en,
    // Comparator and conversion log
    output logic contact_in = 1'b0,
    output int conv_count = 0,
    output logic [15:0] mux_log = 16'h0000,
    output int gap = 0
);
    int cyc = 0; // Free cycle count
    int last = 0; // Cycle of the previous conversion
    // Comparator is meaningless with detection off, so it wanders
    always @(posedge clk) begin
        contact_in <= detect_en ? touch : ~contact_in;
    end
    // Log each conversion and its spacing
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (adc_convert) begin
            conv_count <= conv_count + 1;
            mux_log <= {mux_log[13:0], adc_mux};
            gap <= cyc - last;
            last <= cyc;
        end
    end
endmodule // panel_model

// file: testbench.sv
`timescale 1ns/1ns
`include "touch_consts.vh"
module testbench;
    localparam int SLOT = 20; // Short slot keeps the run brief
    logic CLK = 0;
    logic RST_B = 0;
    logic [11:0] aw_addr = 0, ar_addr = 0;
    logic [31:0] w_data = 0, rd;
    logic aw_valid = 0, w_valid = 0, b_ready = 0, ar_valid = 0, r_ready = 0, touch = 0;
    wire aw_ready, w_ready, b_valid, ar_ready, r_valid, contact, convert, det_en, irq;
    wire [1:0] b_resp, r_resp, mux;
    wire [31:0] r_data;
    wire [3:0] sw;
    logic [1:0] resp;
    logic [15:0] mux_log;
    int errors = 0, n_checks = 0, conv_count, gap, c0;
    always #2 CLK = ~CLK;
    touch_sequence_scheduler #(.SLOT_CYCLES(SLOT)) dut (.CLK(CLK), .RST_B(RST_B),
        .S_AXI_AWADDR(aw_addr), .S_AXI_AWVALID(aw_valid), .S_AXI_AWREADY(aw_ready),
        .S_AXI_WDATA(w_data), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(w_valid),
        .S_AXI_WREADY(w_ready), .S_AXI_BRESP(b_resp), .S_AXI_BVALID(b_valid),
        .S_AXI_BREADY(b_ready), .S_AXI_ARADDR(ar_addr), .S_AXI_ARVALID(ar_valid),
        .S_AXI_ARREADY(ar_ready), .S_AXI_RDATA(r_data), .S_AXI_RRESP(r_resp),
        .S_AXI_RVALID(r_valid), .S_AXI_RREADY(r_ready), .CONTACT_IN(contact),
        .PANEL_SW(sw), .ADC_MUX(mux), .ADC_CONVERT(convert), .DETECT_EN(det_en), .IRQ(irq));
    panel_model u_panel (.clk(CLK), .touch(touch), .adc_mux(mux), .adc_convert(convert),
        .detect_en(det_en), .contact_in(contact), .conv_count(conv_count),
        .mux_log(mux_log), .gap(gap));
    task finish_test;
        if (errors == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Write one register; readies sampled mid-cycle, acted on at the edge
    // No local limit: a missing answer is left to the watchdog
    task automatic wr(input logic [9:0] idx, input logic [7:0] d);
        logic ta, tw, tb;
        @(posedge CLK);
        aw_addr <= {idx, 2'b00};
        w_data <= {24'h0, d};
        aw_valid <= 1;
        w_valid <= 1;
        b_ready <= 1;
        do begin
            @(negedge CLK);
            ta = aw_valid && aw_ready;
            tw = w_valid && w_ready;
            tb = b_valid;
            resp = b_resp;
            @(posedge CLK);
            if (ta) aw_valid <= 0;
            if (tw) w_valid <= 0;
        end while (!tb);
        b_ready <= 0;
    endtask
    // Read one register into rd and resp
    task automatic rdr(input logic [9:0] idx);
        logic ta, tr;
        @(posedge CLK);
        ar_addr <= {idx, 2'b00};
        ar_valid <= 1;
        r_ready <= 1;
        do begin
            @(negedge CLK);
            ta = ar_valid && ar_ready;
            tr = r_valid;
            rd = r_data;
            resp = r_resp;
            @(posedge CLK);
            if (ta) ar_valid <= 0;
        end while (!tr);
        r_ready <= 0;
    endtask
    task wait_slots(input int n);
        repeat (n * SLOT) @(posedge CLK);
    endtask
    task t_regs;
        rdr(`CTRL_INDEX);
        chk("ctrl reset", `CTRL_RESET, rd);
        wr(`CTRL_INDEX, 8'hF8);
        rdr(`CTRL_INDEX);
        chk("ctrl readback", 32'hF8, rd);
        wr(`CTRL_INDEX, 8'h00);
        rdr(10'h000);
        chk("unmapped read", `RESP_SLVERR, resp);
        wr(10'h3FF, 8'h01);
        chk("unmapped write", `RESP_SLVERR, resp);
        rdr(`STATE_INDEX);
        chk("contact idle", 0, rd[0]);
    endtask
    // One manual sequence; count, mux order and spacing of conversions
    task t_seq(input logic [7:0] ctrl, input int n, input logic [31:0] log, input int g);
        wr(`CTRL_INDEX, ctrl);
        c0 = conv_count;
        wr(`START_INDEX, 8'h40);
        wait_slots(40);
        chk("conversions", n, conv_count - c0);
        chk("mux order", log, {16'h0, mux_log} & ((32'h1 << (2 * n)) - 1));
        if (n > 1) chk("settle gap", g, gap);
        rdr(`START_INDEX);
        chk("manual clear", 0, rd[6]);
        wr(`CTRL_INDEX, 8'h00);
    endtask
    task t_off;
        touch <= 1;
        wr(`CTRL_INDEX, 8'h04);
        c0 = conv_count;
        wr(`START_INDEX, 8'h40);
        wait_slots(20);
        chk("auto off", c0, conv_count);
        wr(`CTRL_INDEX, 8'h01);
        wait_slots(20);
        chk("detect off", c0, conv_count);
        chk("detect pin off", 0, det_en);
        touch <= 0;
        wr(`CTRL_INDEX, 8'h00);
    endtask
    // Repeats while touched, spaced by the idle code, stop on release
    task automatic t_repeat;
        int code[5] = '{0, 1, 3, 2, 4};
        int idle[5] = '{0, 2, 10, 5, 30};
        int g[5];
        for (int i = 0; i < 5; i++) begin
            touch <= 1;
            c0 = conv_count;
            wr(`CTRL_INDEX, 8'(7 | (code[i] << 3)));
            wait_slots(3 * (idle[i] + 5));
            g[i] = gap;
            chk("repeating", 1, conv_count - c0 >= 3);
            touch <= 0;
            wait_slots(idle[i] + 8);
            c0 = conv_count;
            wait_slots(idle[i] + 8);
            chk("stop on release", c0, conv_count);
            chk("detect pin on", 1, det_en);
            chk("switches open", 0, sw);
            wr(`CTRL_INDEX, 8'h00);
        end
        chk("idle two", 2 * SLOT, g[1] - g[0]);
        chk("idle ten", 10 * SLOT, g[2] - g[0]);
        chk("idle five", 5 * SLOT, g[3] - g[0]);
        chk("idle thirty", 30 * SLOT, g[4] - g[0]);
    endtask
    task t_irq;
        wr(`MASK_INDEX, 8'h01);
        wr(`STATUS_INDEX, 8'h07);
        @(negedge CLK);
        chk("irq clear", 0, irq);
        wr(`CTRL_INDEX, 8'h05);
        wr(`START_INDEX, 8'h40);
        wait_slots(10);
        @(negedge CLK);
        chk("irq raised", 1, irq);
        wr(`STATUS_INDEX, 8'h01);
        @(negedge CLK);
        chk("irq w1c", 0, irq);
        wr(`MASK_INDEX, 8'h00);
        wr(`START_INDEX, 8'h40);
        wait_slots(10);
        @(negedge CLK);
        chk("irq masked", 0, irq);
        rdr(`STATUS_INDEX);
        chk("status done", 1, rd[0]);
        wr(`CTRL_INDEX, 8'h00);
    endtask
    // Cut a hang short
    initial begin
        repeat (40000) @(posedge CLK);
        errors++;
        finish_test;
    end
    initial begin
        static int st[4] = '{0, 1, 2, 4};
        repeat (3) @(posedge CLK);
        RST_B <= 1;
        repeat (3) @(posedge CLK);
        t_regs;
        t_seq(8'h05, 1, 32'h1, 0);
        for (int s = 0; s < 4; s++) t_seq(8'(1 | (s << 6)), 5, 32'h104, (st[s] + 2) * SLOT);
        t_off;
        t_repeat;
        t_irq;
        finish_test;
    end
endmodule // testbench
